// file: hcd_defines.vh
`ifndef HCD_DEFINES_VH
`define HCD_DEFINES_VH

// command identifiers
`define HCD_CMD_POSTMORTEM   16'h0001
`define HCD_CMD_UPLOAD       16'h0002
`define HCD_CMD_BOOT         16'h0003
`define HCD_CMD_INJ_MODE     16'h0007
`define HCD_CMD_INJ_DATA     16'h0008
`define HCD_CMD_FLUSH        16'h0009
`define HCD_CMD_PASSTHRU     16'h000a
`define HCD_CMD_SELFTEST     16'h000b
`define HCD_CMD_OCMP         16'h000c
`define HCD_CMD_CFG_LO       16'h000d
`define HCD_CMD_CFG_HI       16'h0010
`define HCD_CMD_TST_CONT     16'h0011
`define HCD_CMD_TST_START    16'h0012
`define HCD_CMD_FIFO_FMT     16'h0015
`define HCD_CMD_SPEED        16'h0017
`define HCD_CMD_PSET_LO      16'h0100
`define HCD_CMD_PSET_HI      16'h0fff
`define HCD_CMD_PGET_LO      16'h1000
`define HCD_CMD_PGET_HI      16'h1fff

// response class codes
`define HCD_RSP_NONE         4'h0
`define HCD_RSP_CRASH        4'h1
`define HCD_RSP_INJ_CFG      4'h2
`define HCD_RSP_PASSTHRU     4'h3
`define HCD_RSP_SELFTEST     4'h4
`define HCD_RSP_OCMP         4'h5
`define HCD_RSP_TST          4'h6
`define HCD_RSP_SPEED        4'h7
`define HCD_RSP_PSET         4'h8
`define HCD_RSP_PGET         4'h9
`define HCD_RSP_ERROR        4'hf

// crash dump packet layout
`define HCD_CRASH_CODE       16'h0003
`define HCD_DUMP_BYTES       8'hcd
`define HCD_DUMP_LEN         16'h00c9
`define HCD_OFS_CTX          8'h04
`define HCD_OFS_VALID        8'h84
`define HCD_OFS_FLAGS        8'h85
`define HCD_OFS_STKSZ        8'h86
`define HCD_OFS_STKST        8'h88
`define HCD_OFS_EXC          8'h8c
`define HCD_OFS_DBGVAL       8'ha8
`define HCD_OFS_RSTRSN       8'had
`define HCD_OFS_HRSTCNT      8'hae
`define HCD_OFS_ERRREP       8'haf
`define HCD_OFS_PROT         8'hb0
`define HCD_OFS_USP          8'hb4
`define HCD_OFS_RSVD         8'hb8

// reset reasons and error causes
`define HCD_RST_POR          8'h00
`define HCD_RST_EXT          8'h01
`define HCD_RST_HOST         8'h02
`define HCD_RST_WDOG         8'h04
`define HCD_ERR_WDOG         8'h19
`define HCD_ERR_FATAL        8'h1b
`define HCD_ERR_UNHANDLED    8'h44

// wishbone register offsets
`define HCD_REG_CTRL         8'h00
`define HCD_REG_STATUS       8'h04
`define HCD_REG_IRQ_STAT     8'h08
`define HCD_REG_IRQ_MASK     8'h0c
`define HCD_REG_LAST_CMD     8'h10
`define HCD_REG_CTX_ADDR     8'h14
`define HCD_REG_CTX_DATA     8'h18
`define HCD_REG_INFO         8'h1c
`define HCD_REG_STACK        8'h20
`define HCD_REG_EXC_ADDR     8'h24
`define HCD_REG_EXC_DATA     8'h28

// control and irq bits
`define HCD_CTRL_RUNTIME     0
`define HCD_IRQ_CMD          0
`define HCD_IRQ_ERR          1
`define HCD_IRQ_DUMP         2

`endif

// file: hcd_ctx_mem.v
`default_nettype none

// simple two-port word store for the saved context, one write and one read port, registered read
module hcd_ctx_mem (
    // clock
    input  wire        clk_i,
    // write port
    input  wire        we_i,
    input  wire [4:0]  waddr_i,
    input  wire [31:0] wdata_i,
    // read port
    input  wire [4:0]  raddr_i,
    output reg  [31:0] rdata_o
);
    reg [31:0] mem [0:31];

    // read data from a flop so it maps onto block ram
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // hcd_ctx_mem

`default_nettype wire

// file: hcd_decoder.v
`include "hcd_defines.vh"
`default_nettype none

// Summary of operation
// - post-mortem command is id 0x0001 with zero length and nothing else
// - post-mortem command streams all stored crash data onto the status channel
// - dump starts with code 0x0003 then two-byte count of following bytes
// - bytes 0x04-0x83 carry the 32 saved context registers
// - byte 0x84 is 0 without crash info, 1 after a crash
// - byte 0x85 holds the four validity and no-autoexec flags
// - bytes 0x86-0x87 stack size, 0x88-0x8b stack start address
// - bytes 0xa8-0xac copy the five host debug and interrupt registers
// - byte 0xad reset reason: 0 por, 1 pin, 2 host, 4 watchdog
// - byte 0xaf error cause: 0x19 watchdog, 0x1b fatal, 0x44 unhandled
// - bytes 0xb0-0xb3 protection fault cause, 0xb4-0xb7 user stack pointer
// - bootloader accepts only 0x0001-0x0003 and 0x0017; rest need runtime
// - listed silent commands give no packet when they succeed
// - self-test, offset, test and pass-through commands return result packets; code only flags their class on cmd_rsp_o
// - 0x0100-0x0fff parameter write, 0x1000-0x1fff read, others reserved
// - malformed or invalid commands always get a command error packet; code flags 0xf on cmd_rsp_o and ignores bytes sent during a dump
module hcd_decoder (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // command byte stream from the host port
    input  wire        cmd_valid_i,
    input  wire [7:0]  cmd_byte_i,
    input  wire        cmd_end_i,
    // status byte stream to the host port
    output reg         sts_valid_o,
    output reg  [7:0]  sts_byte_o,
    output reg         sts_last_o,
    input  wire        sts_ready_i,
    // decoded command
    output reg         cmd_exec_o,
    output reg  [15:0] cmd_id_o,
    output reg  [3:0]  cmd_rsp_o,
    // interrupt
    output wire        irq_o
);
    // classification of an identifier: response class or error when refused
    function [3:0] hcd_classify;
        input [15:0] id;
        input        rt;
        begin
            hcd_classify = `HCD_RSP_ERROR;
            if (!rt) begin
                if (id == `HCD_CMD_POSTMORTEM)
                    hcd_classify = `HCD_RSP_CRASH;
                else if (id == `HCD_CMD_UPLOAD || id == `HCD_CMD_BOOT)
                    hcd_classify = `HCD_RSP_NONE;
                else if (id == `HCD_CMD_SPEED)
                    hcd_classify = `HCD_RSP_SPEED;
            end else begin
                if (id == `HCD_CMD_INJ_MODE)
                    hcd_classify = `HCD_RSP_INJ_CFG;
                else if (id == `HCD_CMD_INJ_DATA || id == `HCD_CMD_FLUSH ||
                         id == `HCD_CMD_FIFO_FMT ||
                         (id >= `HCD_CMD_CFG_LO && id <= `HCD_CMD_CFG_HI))
                    hcd_classify = `HCD_RSP_NONE;
                else if (id == `HCD_CMD_PASSTHRU)
                    hcd_classify = `HCD_RSP_PASSTHRU;
                else if (id == `HCD_CMD_SELFTEST)
                    hcd_classify = `HCD_RSP_SELFTEST;
                else if (id == `HCD_CMD_OCMP)
                    hcd_classify = `HCD_RSP_OCMP;
                else if (id == `HCD_CMD_TST_CONT || id == `HCD_CMD_TST_START)
                    hcd_classify = `HCD_RSP_TST;
                else if (id >= `HCD_CMD_PSET_LO && id <= `HCD_CMD_PSET_HI)
                    hcd_classify = `HCD_RSP_PSET;
                else if (id >= `HCD_CMD_PGET_LO && id <= `HCD_CMD_PGET_HI)
                    hcd_classify = `HCD_RSP_PGET;
            end
        end
    endfunction

    // byte lane of a word, low byte first
    function [7:0] hcd_lane;
        input [31:0] w;
        input [1:0]  n;
        begin
            hcd_lane = w[8*n +: 8];
        end
    endfunction

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RECV = 3'b010;
    localparam [2:0] ST_DUMP = 3'b100;

    reg [2:0]  state_q;
    reg [15:0] id_q;
    reg [15:0] len_q;
    reg [15:0] cnt_q;
    reg        ctrl_rt_q;
    reg [2:0]  irq_stat_q;
    reg [2:0]  irq_mask_q;
    reg [7:0]  pos_q;
    reg        crash_valid_q;
    reg [7:0]  flags_q;
    reg [15:0] stk_size_q;
    reg [31:0] stk_start_q;
    reg [31:0] exc_q [0:10];
    reg [7:0]  info_q [0:7];
    reg [3:0]  exc_idx_q;
    reg [4:0]  ctx_idx_q;
    reg [7:0]  err_count_q;

    wire       wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr  = wb_hit & wb_we_i;
    wire [4:0] ctx_rd_addr;
    wire [31:0] ctx_rd_data;
    wire       ctx_we = wb_wr & (wb_adr_i == `HCD_REG_CTX_DATA);
    wire [7:0] nxt_pos = pos_q + 8'h01;
    wire [7:0] pos_d = (state_q == ST_DUMP && (!sts_valid_o || sts_ready_i)) ? nxt_pos : pos_q;
    wire       irq_cmd_ev;
    wire       irq_err_ev;
    wire       irq_dump_ev;

    // context lookahead: word of the byte loaded next cycle
    assign ctx_rd_addr = pos_d[6:2] - 5'h01;

    hcd_ctx_mem u_ctx (
        .clk_i   (clk_i),
        .we_i    (ctx_we),
        .waddr_i (ctx_idx_q),
        .wdata_i (wb_dat_i),
        .raddr_i ((state_q == ST_DUMP) ? ctx_rd_addr : 5'h00),
        .rdata_o (ctx_rd_data)
    );

    // command framing: id and length low byte first, then payload count
    wire       frame_done = (state_q == ST_RECV) & cmd_valid_i & cmd_end_i;
    wire [15:0] id_f  = (cnt_q == 16'h0001) ? {cmd_byte_i, id_q[7:0]} : id_q;
    wire [15:0] len_f = (cnt_q == 16'h0002) ? {8'h00, cmd_byte_i} :
                        (cnt_q == 16'h0003) ? {cmd_byte_i, len_q[7:0]} : len_q;
    wire [15:0] cnt_f = cnt_q + 16'h0001;
    wire [15:0] pay_f = (cnt_f > 16'h0004) ? cnt_f - 16'h0004 : 16'h0000;
    wire [3:0]  cls_f = hcd_classify(id_f, ctrl_rt_q);
    // speed command has its own fixed four byte payload
    wire        fmt_ok = (id_f == `HCD_CMD_SPEED) ? (cnt_f == 16'h0008) :
                         (cnt_f >= 16'h0004 && pay_f == len_f);
    wire        pm_ok  = (id_f != `HCD_CMD_POSTMORTEM) || (len_f == 16'h0000);
    wire        bad_f  = ~fmt_ok | ~pm_ok | (cls_f == `HCD_RSP_ERROR);

    assign irq_cmd_ev  = frame_done & ~bad_f;
    assign irq_err_ev  = frame_done & bad_f;
    assign irq_dump_ev = (state_q == ST_DUMP) & sts_ready_i & sts_last_o & sts_valid_o;

    // receive and dump sequencing
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ST_IDLE;
            id_q        <= 16'h0000;
            len_q       <= 16'h0000;
            cnt_q       <= 16'h0000;
            pos_q       <= 8'h00;
            cmd_exec_o  <= 1'b0;
            cmd_id_o    <= 16'h0000;
            cmd_rsp_o   <= `HCD_RSP_NONE;
            err_count_q <= 8'h00;
        end else begin
            cmd_exec_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_valid_i) begin
                        id_q  <= {8'h00, cmd_byte_i};
                        cnt_q <= 16'h0001;
                        if (cmd_end_i) begin
                            // a one byte command is always garbled
                            cmd_exec_o  <= 1'b1;
                            cmd_id_o    <= {8'h00, cmd_byte_i};
                            cmd_rsp_o   <= `HCD_RSP_ERROR;
                            err_count_q <= err_count_q + 8'h01;
                        end else begin
                            state_q <= ST_RECV;
                        end
                    end
                end
                ST_RECV: begin
                    if (cmd_valid_i) begin
                        id_q  <= id_f;
                        len_q <= len_f;
                        if (cnt_q != 16'hffff)
                            cnt_q <= cnt_f;
                        if (cmd_end_i) begin
                            cmd_exec_o <= 1'b1;
                            cmd_id_o   <= id_f;
                            cmd_rsp_o  <= bad_f ? `HCD_RSP_ERROR : cls_f;
                            if (bad_f)
                                err_count_q <= err_count_q + 8'h01;
                            if (!bad_f && cls_f == `HCD_RSP_CRASH) begin
                                state_q <= ST_DUMP;
                                pos_q   <= 8'h00;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_DUMP: begin
                    // dump ignores new command bytes until the last byte leaves
                    pos_q <= pos_d;
                    if (sts_valid_o && sts_ready_i && sts_last_o)
                        state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // byte select for the crash dump packet
    reg [7:0] dump_byte;
    reg [7:0] rel;
    always @* begin
        dump_byte = 8'h00;
        rel       = pos_q - `HCD_OFS_EXC;
        if (pos_q < 8'h02)
            dump_byte = hcd_lane({16'h0000, `HCD_CRASH_CODE}, pos_q[1:0]);
        else if (pos_q < `HCD_OFS_CTX)
            dump_byte = hcd_lane({16'h0000, `HCD_DUMP_LEN}, pos_q[1:0] - 2'd2);
        else if (pos_q < `HCD_OFS_VALID)
            dump_byte = hcd_lane(ctx_rd_data, pos_q[1:0]);
        else if (pos_q == `HCD_OFS_VALID)
            dump_byte = {7'h00, crash_valid_q};
        else if (pos_q == `HCD_OFS_FLAGS)
            dump_byte = {4'h0, flags_q[3:0]};
        else if (pos_q < `HCD_OFS_STKST)
            dump_byte = hcd_lane({16'h0000, stk_size_q}, pos_q[1:0] - 2'd2);
        else if (pos_q < `HCD_OFS_EXC)
            dump_byte = hcd_lane(stk_start_q, pos_q[1:0]);
        else if (pos_q < `HCD_OFS_DBGVAL)
            dump_byte = hcd_lane(exc_q[rel[5:2]], pos_q[1:0]);
        else if (pos_q < `HCD_OFS_PROT)
            dump_byte = info_q[pos_q[2:0]];
        else if (pos_q < `HCD_OFS_RSVD)
            dump_byte = hcd_lane(exc_q[rel[5:2]], pos_q[1:0]);
    end

    // status stream: dump packets only; errors and other responses go via cmd_rsp_o
    always @(posedge clk_i) begin
        if (rst_i) begin
            sts_valid_o <= 1'b0;
            sts_byte_o  <= 8'h00;
            sts_last_o  <= 1'b0;
        end else if (state_q == ST_DUMP) begin
            if (!sts_valid_o || sts_ready_i) begin
                sts_valid_o <= ~(sts_valid_o & sts_last_o);
                sts_byte_o  <= dump_byte;
                sts_last_o  <= (pos_q == `HCD_DUMP_BYTES - 8'h01);
            end
        end else begin
            sts_valid_o <= 1'b0;
            sts_last_o  <= 1'b0;
        end
    end

    // software writes: control, stored crash record, irq handling
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_rt_q     <= 1'b0;
            irq_stat_q    <= 3'h0;
            irq_mask_q    <= 3'h0;
            crash_valid_q <= 1'b0;
            flags_q       <= 8'h00;
            stk_size_q    <= 16'h0000;
            stk_start_q   <= 32'h0000_0000;
            exc_idx_q     <= 4'h0;
            ctx_idx_q     <= 5'h00;
            for (i = 0; i < 11; i = i + 1)
                exc_q[i] <= 32'h0000_0000;
            for (i = 0; i < 8; i = i + 1)
                info_q[i] <= 8'h00;
        end else begin
            // a new event wins over a write-one clear in the same cycle
            irq_stat_q <= (irq_stat_q &
                           ~((wb_wr && wb_adr_i == `HCD_REG_IRQ_STAT && wb_sel_i[0]) ?
                             wb_dat_i[2:0] : 3'h0)) |
                          {irq_dump_ev, irq_err_ev, irq_cmd_ev};
            if (wb_wr) begin
                case (wb_adr_i)
                    `HCD_REG_CTRL: begin
                        if (wb_sel_i[0])
                            ctrl_rt_q <= wb_dat_i[`HCD_CTRL_RUNTIME];
                    end
                    `HCD_REG_IRQ_MASK: begin
                        if (wb_sel_i[0])
                            irq_mask_q <= wb_dat_i[2:0];
                    end
                    `HCD_REG_CTX_ADDR: begin
                        if (wb_sel_i[0])
                            ctx_idx_q <= wb_dat_i[4:0];
                    end
                    `HCD_REG_CTX_DATA: begin
                        ctx_idx_q <= ctx_idx_q + 5'h01;
                    end
                    `HCD_REG_INFO: begin
                        if (wb_sel_i[0])
                            crash_valid_q <= wb_dat_i[0];
                        if (wb_sel_i[1])
                            flags_q <= {4'h0, wb_dat_i[11:8]};
                        if (wb_sel_i[3])
                            stk_size_q[15:8] <= wb_dat_i[31:24];
                        if (wb_sel_i[2])
                            stk_size_q[7:0] <= wb_dat_i[23:16];
                    end
                    `HCD_REG_STACK: begin
                        stk_start_q <= wb_dat_i;
                    end
                    `HCD_REG_EXC_ADDR: begin
                        if (wb_sel_i[0])
                            exc_idx_q <= wb_dat_i[3:0];
                    end
                    `HCD_REG_EXC_DATA: begin
                        // words 0-4 exception, 5 diag, 6 icause, 7-8 info, 9-10 prot/usp
                        if (exc_idx_q == 4'h7 || exc_idx_q == 4'h8) begin
                            for (i = 0; i < 4; i = i + 1)
                                info_q[{exc_idx_q[0], i[1:0]}] <=
                                    wb_dat_i[8*i +: 8];
                        end else if (exc_idx_q < 4'hb) begin
                            exc_q[exc_idx_q] <= wb_dat_i;
                        end
                        exc_idx_q <= exc_idx_q + 4'h1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // wishbone answer one cycle after the strobe, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `HCD_REG_CTRL:     wb_dat_o <= {31'h0, ctrl_rt_q};
                    `HCD_REG_STATUS:   wb_dat_o <= {21'h0, err_count_q, state_q};
                    `HCD_REG_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
                    `HCD_REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
                    `HCD_REG_LAST_CMD: wb_dat_o <= {12'h0, cmd_rsp_o, cmd_id_o};
                    `HCD_REG_INFO:     wb_dat_o <= {stk_size_q, flags_q,
                                                    7'h0, crash_valid_q};
                    `HCD_REG_STACK:    wb_dat_o <= stk_start_q;
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule // hcd_decoder

`default_nettype wire

// file: hcd_decoder_properties.sv
`default_nettype none
// port-level watch of the decoder's command and status streams
module hcd_decoder_props (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // command side
    input wire logic        cmd_valid_i,
    input wire logic        cmd_end_i,
    input wire logic        cmd_exec_o,
    input wire logic [15:0] cmd_id_o,
    input wire logic [3:0]  cmd_rsp_o,
    // status side
    input wire logic        sts_valid_o,
    input wire logic [7:0]  sts_byte_o,
    input wire logic        sts_last_o,
    input wire logic        sts_ready_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // dump byte index, back to zero after the last byte
    logic [7:0] idx_q;
    wire logic [7:0] idx_d = !(sts_valid_o && sts_ready_i) ? idx_q :
                             sts_last_o ? 8'h00 : idx_q + 8'h01;
    always @(posedge clk_i) idx_q <= rst_i ? 8'h00 : idx_d;
    property p_exec_cause; cmd_exec_o |-> $past(cmd_valid_i && cmd_end_i); endproperty
    a_exec_cause: assert property (p_exec_cause) else $error("answer without end byte");
    property p_hold; sts_valid_o && !sts_ready_i |=> sts_valid_o && $stable(sts_byte_o); endproperty
    a_hold: assert property (p_hold) else $error("status byte dropped");
    property p_start; cmd_exec_o && cmd_rsp_o == 4'h1 |-> ##[1:6] sts_valid_o && sts_byte_o == 8'h03; endproperty
    a_start: assert property (p_start) else $error("dump did not start");
    property p_len; sts_valid_o && idx_q == 8'h02 |-> sts_byte_o == 8'hc9; endproperty
    a_len: assert property (p_len) else $error("bad dump count");
    property p_last; sts_valid_o |-> sts_last_o == (idx_q == 8'hcc); endproperty
    a_last: assert property (p_last) else $error("bad last byte");
    property p_valid; sts_valid_o && idx_q == 8'h84 |-> sts_byte_o[7:1] == 7'h00; endproperty
    a_valid: assert property (p_valid) else $error("bad validity byte");
    property p_rsvd; sts_valid_o && idx_q >= 8'hb8 |-> sts_byte_o == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
    property p_silent; cmd_exec_o && cmd_rsp_o == 4'h0 |-> cmd_id_o inside
        {16'h0002, 16'h0003, 16'h0008, 16'h0009, [16'h000d:16'h0010], 16'h0015}; endproperty
    a_silent: assert property (p_silent) else $error("silent answer for wrong id");
endmodule // hcd_decoder_props
bind hcd_decoder hcd_decoder_props hcd_decoder_props_i (.clk_i, .rst_i, .cmd_valid_i,
    .cmd_end_i, .cmd_exec_o, .cmd_id_o, .cmd_rsp_o, .sts_valid_o, .sts_byte_o, .sts_last_o,
    .sts_ready_i);
`default_nettype wire

// file: hcd_host_model.sv
`default_nettype none
// host end of the status channel: drains promptly or with random stalls
module hcd_host_model (
    // clock
    input  wire logic clk_i,
    // status handshake and pacing
    output var  logic sts_ready_o,
    input  wire logic slow_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // host always drains the channel; slow mode stalls to stress the hold
    initial sts_ready_o = 1'b0;
    always @(posedge clk_i) sts_ready_o <= slow_i ? $urandom % 3 == 0 : 1'b1;
endmodule // hcd_host_model
`default_nettype wire

// file: tb.sv
`include "hcd_defines.vh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
// bench for the host command decoder
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // design inputs
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        cmd_valid_i = 1'b0, cmd_end_i = 1'b0, slow = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, cmd_byte_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    // design outputs
    logic        wb_ack_o, sts_valid_o, sts_last_o, sts_ready_i, cmd_exec_o, irq_o;
    logic [7:0]  sts_byte_o;
    logic [3:0]  cmd_rsp_o;
    logic [15:0] cmd_id_o;
    logic [31:0] wb_dat_o;
    // notes of expected results, oldest first
    logic [19:0] q_rsp [$], er;
    logic [8:0]  q_sts [$], es;
    logic [31:0] q_rd [$], ew, stk, info, ctx [32], exc [11];
    logic [7:0]  pos [11] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4, 8'hac, 8'ha8,
                              8'hb0, 8'hb4};
    logic [19:0] tab [29] = '{20'h00002, 20'h00003, 20'h70017, 20'hf000b, 20'hf0100, 20'hf1000,
        20'h20007, 20'h00008, 20'h00009, 20'h3000a, 20'h4000b, 20'h5000c, 20'h0000d, 20'h0000e,
        20'h0000f, 20'h00010, 20'h60011, 20'h60012, 20'h00015, 20'h80100, 20'h80fff, 20'h91000,
        20'h91fff, 20'hf0001, 20'hf0017, 20'hf0004, 20'hf00ff, 20'hf2000, 20'hf0003};
    int          failures = 0, checked = 0;
    hcd_decoder hcd_decoder_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_valid_i, .cmd_byte_i, .cmd_end_i,
        .sts_valid_o, .sts_byte_o, .sts_last_o, .sts_ready_i, .cmd_exec_o, .cmd_id_o,
        .cmd_rsp_o, .irq_o);
    hcd_host_model hcd_host_model_i (.clk_i, .sts_ready_o(sts_ready_i), .slow_i(slow));
    initial forever #4 clk_i = ~clk_i;
    task automatic final_report();
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // each result takes the oldest note; a missing note compares against x
    always @(posedge clk_i) begin
        if (cmd_exec_o === 1'b1) begin
            er = q_rsp.size() ? q_rsp.pop_front() : 20'hx;
            `CHK({cmd_rsp_o, cmd_id_o}, er)
        end
        if (sts_valid_o === 1'b1 && sts_ready_i === 1'b1) begin
            es = q_sts.size() ? q_sts.pop_front() : 9'hx;
            `CHK({sts_last_o, sts_byte_o}, es)
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            ew = q_rd.size() ? q_rd.pop_front() : 32'hx;
            `CHK(wb_dat_o, ew)
        end
    end
    // one classic cycle; a read notes its expected word first
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        if (!we)
            q_rd.push_back(d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= we ? d : 32'h0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n == 50) begin
            failures++;
            final_report();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // id and length low byte first, then payload; waits until all answers drained
    task automatic cmd(input logic [15:0] id, input logic [15:0] len, input int n,
                       input logic [3:0] rsp);
        int w;
        q_rsp.push_back({rsp, id});
        for (int i = 0; i < n; i++) begin
            cmd_valid_i <= 1'b1;
            cmd_byte_i <= i < 4 ? 8'({len, id} >> (8 * i)) : 8'($urandom);
            cmd_end_i <= i == n - 1;
            @(posedge clk_i);
        end
        cmd_valid_i <= 1'b0;
        cmd_end_i <= 1'b0;
        w = 0;
        while ((q_rsp.size() || q_sts.size()) && w < 3000) begin
            @(posedge clk_i);
            w++;
        end
        if (w == 3000) begin
            failures++;
            final_report();
        end
        repeat (2) @(posedge clk_i);
    endtask
    // expected crash packet from the words loaded into the stores
    task automatic dump_exp();
        logic [7:0] m [256];
        foreach (m[i]) m[i] = 8'h00;
        {m[3], m[2], m[1], m[0]} = 32'h00c9_0003;
        for (int i = 0; i < 32; i++) {m[4*i+7], m[4*i+6], m[4*i+5], m[4*i+4]} = ctx[i];
        for (int i = 0; i < 11; i++) {m[pos[i]+3], m[pos[i]+2], m[pos[i]+1], m[pos[i]]} = exc[i];
        {m[8'h8b], m[8'h8a], m[8'h89], m[8'h88], m[8'h87], m[8'h86], m[8'h85], m[8'h84]} =
            {stk, info[31:16], 4'h0, info[11:8], 7'h0, info[0]};
        for (int i = 0; i < 205; i++) q_sts.push_back({i == 204, m[i]});
    endtask
    initial begin
        void'($urandom(32'h4e828a1c));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // random context and exception words, auto-incremented
        bus(1'b1, `HCD_REG_CTX_ADDR, 32'h0);
        foreach (ctx[i]) begin
            ctx[i] = $urandom;
            bus(1'b1, `HCD_REG_CTX_DATA, ctx[i]);
        end
        bus(1'b1, `HCD_REG_EXC_ADDR, 32'h0);
        foreach (exc[i]) begin
            exc[i] = $urandom;
            bus(1'b1, `HCD_REG_EXC_DATA, exc[i]);
        end
        stk = $urandom;
        bus(1'b1, `HCD_REG_STACK, stk);
        bus(1'b0, `HCD_REG_STACK, stk);
        bus(1'b0, 8'h40, 32'h0);
        bus(1'b1, `HCD_REG_IRQ_MASK, 32'h2);
        // every reset reason and cause, prompt and stalled host, both validity values
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            info = {16'($urandom), 4'h0, 4'($urandom), 7'h0, k[1]};
            exc[7] = {k == 1 ? 8'h1b : k == 2 ? 8'h44 : 8'h19, 8'($urandom),
                      8'(k == 3 ? 4 : k), 8'($urandom)};
            bus(1'b1, `HCD_REG_INFO, info);
            bus(1'b1, `HCD_REG_EXC_ADDR, 32'h7);
            bus(1'b1, `HCD_REG_EXC_DATA, exc[7]);
            dump_exp();
            cmd(16'h0001, 16'h0, 4, 4'h1);
        end
        bus(1'b0, `HCD_REG_INFO, info);
        // error status is sticky, masked, then cleared
        `CHK(irq_o, 1'b0)
        cmd(16'h0001, 16'h1, 5, 4'hf);
        `CHK(irq_o, 1'b1)
        bus(1'b1, `HCD_REG_IRQ_MASK, 32'h0);
        `CHK(irq_o, 1'b0)
        bus(1'b1, `HCD_REG_IRQ_STAT, 32'h7);
        bus(1'b1, `HCD_REG_IRQ_MASK, 32'h2);
        `CHK(irq_o, 1'b0)
        cmd(16'h0001, 16'h0, 3, 4'hf);
        // bootloader entries first, runtime from entry six
        foreach (tab[k]) begin
            if (k == 6)
                bus(1'b1, `HCD_REG_CTRL, 32'h1);
            cmd(tab[k][15:0], 16'h0, tab[k][15:0] == 16'h0017 ? 8 : 4, tab[k][19:16]);
        end
        cmd(16'h000d, 16'h2, 5, 4'hf);
        cmd(16'h000d, 16'h1, 5, 4'h0);
        final_report();
    end
endmodule // tb
`default_nettype wire
